/* logic/octr_ramp.sv */
`timescale 1ns/1ns
`default_nettype none
// Function
// [RQ1] Start run at configured start current
// [RQ2] Add increment, hold for step time
// [RQ3] End on trip or end current
// [RQ4] Step time 50 ms to 1600 s
// [RQ5] Trigger delay before trip check
// [RQ6] Voltage below trigger level means trip
// [RQ7] Flag protection failure at end current
// [RQ8] Apply final current after trip
// [RQ9] Twelve stored setups select run parameters
// [RQ10] Setup picks high, middle, low range
// [RQ11] Run only in constant-current mode
// [RQ12] Capture voltage and current at trip
// [RQ13] End current set above expected threshold
// [RQ14] Wait for voltage above trigger first
// [RQ15] Load switch-on starts run when enabled
// [RQ16] Clamp next setpoint at end current
// [RQ17] Flag delay not below step time
module octr_ramp
    import octr_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire octr_bus_t bus,
    output logic [31:0] rdata,
    input wire logic load_on,
    input wire logic mode_cc,
    input wire logic [VOLT_W-1:0] meas_v,
    input wire logic [CUR_W-1:0] meas_i,
    output octr_drive_t drive
);
    // A zero divider would never tick and freeze every step
    if (TICK_CYCLES < 1) begin : g_bad_tick
        $error("TICK_CYCLES must be at least one");
    end
    // The longest step time must fit the time field
    if (STEPT_MAX_S * 1000 / TICK_MS > (1 << TIME_W) - 1) begin : g_bad_time
        $error("time field too narrow for the longest step");
    end

    typedef enum logic [2:0] {
        OCTR_IDLE = 3'b000,
        OCTR_ARM = 3'b001,
        OCTR_DELAY = 3'b010,
        OCTR_HOLD = 3'b011,
        OCTR_LAST = 3'b100,
        OCTR_DONE = 3'b101
    } octr_state_t;

    // Setup store, one word set per slot
    octr_setup_t setups_q [SLOTS];
    logic enable_q;
    logic [SLOT_W-1:0] slot_q;
    octr_state_t state_q, state_d;
    logic [CUR_W-1:0] setpt_q, setpt_d;
    logic [TIME_W-1:0] tcnt_q, tcnt_d;
    logic [31:0] div_q;
    logic trip_q, fail_q, load_q;
    logic [VOLT_W-1:0] res_v_q;
    logic [CUR_W-1:0] res_i_q;
    logic [31:0] rdata_q;

    wire octr_setup_t cur = setups_q[slot_q];
    wire tick = (div_q == 32'(TICK_CYCLES - 1));
    wire wr_ok = bus.wr && (slot_q < SLOT_W'(SLOTS));
    // [RQ4] [RQ17] Step time and delay limits
    wire bad_setup = (cur.delay >= cur.step_t) || (cur.step_t < STEPT_MIN)
        || (cur.step_t > STEPT_MAX) || (cur.delay > DELAY_MAX);
    // [RQ15] Switch-on edge
    wire start_ev = load_on && !load_q && enable_q;
    // [RQ6] Collapse of output
    wire volt_low = meas_v < cur.trig_v;
    wire at_end = setpt_q >= cur.end_c;

    // [RQ16] Clamped increment
    function automatic logic [CUR_W-1:0] next_setpt(input logic [CUR_W-1:0] sp,
        input logic [CUR_W-1:0] inc, input logic [CUR_W-1:0] lim);
        logic [CUR_W:0] sum;
        sum = {1'b0, sp} + {1'b0, inc};
        next_setpt = (sum > {1'b0, lim}) ? lim : sum[CUR_W-1:0];
    endfunction

    always_comb begin
        state_d = state_q;
        setpt_d = setpt_q;
        tcnt_d = tick ? tcnt_q + 16'h0001 : tcnt_q;
        case (state_q)
            OCTR_IDLE: begin
                // [RQ11] Constant-current only
                if (start_ev && mode_cc && !bad_setup) begin
                    // [RQ1] Load start current
                    setpt_d = cur.start_c;
                    state_d = OCTR_ARM;
                end
            end
            OCTR_ARM: begin
                tcnt_d = 16'h0000;
                // [RQ14] Wait for supply up
                if (!volt_low) begin
                    state_d = OCTR_DELAY;
                end
            end
            OCTR_DELAY: begin
                // [RQ5] Trip check after delay
                if (tcnt_q >= cur.delay) begin
                    state_d = OCTR_HOLD;
                end
            end
            OCTR_HOLD: begin
                // [RQ3] Trip ends ramp
                if (volt_low) begin
                    state_d = OCTR_LAST;
                end else if (tcnt_q >= cur.step_t) begin
                    // [RQ3] End current reached
                    if (at_end) begin
                        state_d = OCTR_DONE;
                    end else begin
                        // [RQ2] Next step
                        setpt_d = next_setpt(setpt_q, cur.step_c, cur.end_c);
                        tcnt_d = 16'h0000;
                        state_d = OCTR_DELAY;
                    end
                end
            end
            OCTR_LAST: begin
                // [RQ8] Final current
                setpt_d = cur.last_c;
            end
            OCTR_DONE: begin
                setpt_d = 16'h0000;
            end
            default: begin
                state_d = OCTR_IDLE;
            end
        endcase
        // Load off or mode change aborts any run
        if (!load_on || !mode_cc) begin
            state_d = OCTR_IDLE;
            setpt_d = 16'h0000;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset || tick || state_q == OCTR_IDLE || state_q == OCTR_ARM) begin
            div_q <= 32'h00000000;
        end else begin
            div_q <= div_q + 32'h00000001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q <= OCTR_IDLE;
            setpt_q <= 16'h0000;
            tcnt_q <= 16'h0000;
            load_q <= 1'b0;
        end else begin
            state_q <= state_d;
            setpt_q <= setpt_d;
            tcnt_q <= tcnt_d;
            load_q <= load_on;
        end
    end

    // Result capture; start clears both flags, trip or end current captures
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            trip_q <= 1'b0;
            fail_q <= 1'b0;
            res_v_q <= 16'h0000;
            res_i_q <= 16'h0000;
        end else if (state_q == OCTR_HOLD && state_d == OCTR_LAST) begin
            // [RQ12] Capture at trip
            trip_q <= 1'b1;
            res_v_q <= meas_v;
            res_i_q <= meas_i;
        end else if (state_q == OCTR_HOLD && state_d == OCTR_DONE) begin
            // [RQ7] Protection failed
            fail_q <= 1'b1;
            res_v_q <= meas_v;
            res_i_q <= meas_i;
        end else if (state_q == OCTR_IDLE && state_d == OCTR_ARM) begin
            trip_q <= 1'b0;
            fail_q <= 1'b0;
        end
    end

    // [RQ9] Setup writes go to the selected slot
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            enable_q <= 1'b0;
            slot_q <= 4'h0;
            for (int k = 0; k < SLOTS; k++) begin
                setups_q[k] <= '{range: RST_RANGE, step_t: RST_STEPT, default: '0};
            end
        end else if (bus.wr) begin
            case (bus.addr)
                REG_CTRL: enable_q <= bus.wdata[CTRL_EN_BIT];
                REG_SLOT: begin
                    if (bus.wdata[SLOT_W-1:0] < SLOT_W'(SLOTS)) begin
                        slot_q <= bus.wdata[SLOT_W-1:0];
                    end
                end
                REG_RANGE: begin
                    // [RQ10] Range per setup
                    if (wr_ok && bus.wdata[1:0] != 2'h3) begin
                        setups_q[slot_q].range <= bus.wdata[1:0];
                    end
                end
                REG_START: setups_q[slot_q].start_c <= bus.wdata[CUR_W-1:0];
                REG_END: setups_q[slot_q].end_c <= bus.wdata[CUR_W-1:0];
                REG_STEPC: setups_q[slot_q].step_c <= bus.wdata[CUR_W-1:0];
                REG_STEPT: setups_q[slot_q].step_t <= bus.wdata[TIME_W-1:0];
                REG_DELAY: setups_q[slot_q].delay <= bus.wdata[TIME_W-1:0];
                REG_TRIGV: setups_q[slot_q].trig_v <= bus.wdata[VOLT_W-1:0];
                REG_LASTC: setups_q[slot_q].last_c <= bus.wdata[CUR_W-1:0];
                default: ;
            endcase
        end
    end

    logic [31:0] rd_mux;
    always_comb begin
        case (bus.addr)
            REG_CTRL: rd_mux = {31'h0, enable_q};
            REG_SLOT: rd_mux = {28'h0, slot_q};
            REG_RANGE: rd_mux = {30'h0, cur.range};
            REG_START: rd_mux = {16'h0, cur.start_c};
            REG_END: rd_mux = {16'h0, cur.end_c};
            REG_STEPC: rd_mux = {16'h0, cur.step_c};
            REG_STEPT: rd_mux = {16'h0, cur.step_t};
            REG_DELAY: rd_mux = {16'h0, cur.delay};
            REG_TRIGV: rd_mux = {16'h0, cur.trig_v};
            REG_LASTC: rd_mux = {16'h0, cur.last_c};
            REG_STATUS: rd_mux = {27'h0, !mode_cc, bad_setup, fail_q, trip_q,
                state_q != OCTR_IDLE && state_q != OCTR_DONE};
            REG_RES_V: rd_mux = {16'h0, res_v_q};
            REG_RES_I: rd_mux = {16'h0, res_i_q};
            REG_SETPT: rd_mux = {16'h0, setpt_q};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= bus.rd ? rd_mux : 32'h00000000;
        end
    end

    assign rdata = rdata_q;
    assign drive.setpoint = setpt_q;
    assign drive.range = cur.range;
    assign drive.sink_on = state_q != OCTR_IDLE && state_q != OCTR_DONE;

endmodule // octr_ramp
`default_nettype wire

/* inc/octr_pkg.sv */
`default_nettype none
package octr_pkg;
    localparam int CUR_W = 16;
    localparam int VOLT_W = 16;
    localparam int TIME_W = 16;
    localparam int SLOTS = 12;
    localparam int SLOT_W = 4;
    // Register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_SLOT = 8'h01;
    localparam logic [7:0] REG_RANGE = 8'h02;
    localparam logic [7:0] REG_START = 8'h03;
    localparam logic [7:0] REG_END = 8'h04;
    localparam logic [7:0] REG_STEPC = 8'h05;
    localparam logic [7:0] REG_STEPT = 8'h06;
    localparam logic [7:0] REG_DELAY = 8'h07;
    localparam logic [7:0] REG_TRIGV = 8'h08;
    localparam logic [7:0] REG_LASTC = 8'h09;
    localparam logic [7:0] REG_STATUS = 8'h0A;
    localparam logic [7:0] REG_RES_V = 8'h0B;
    localparam logic [7:0] REG_RES_I = 8'h0C;
    localparam logic [7:0] REG_SETPT = 8'h0D;
    // Field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int ST_RUN_BIT = 0;
    localparam int ST_TRIP_BIT = 1;
    localparam int ST_FAIL_BIT = 2;
    localparam int ST_BAD_BIT = 3;
    localparam int ST_NOTCC_BIT = 4;
    // Timing: time fields count in 25 ms units, so 1600 s still fits 16 bits
    localparam int TICK_MS = 25;
    localparam int CLK_HZ = 25000000;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int STEPT_MIN_MS = 50;
    localparam int STEPT_MAX_S = 1600;
    localparam int DELAY_MAX_S = 160;
    localparam logic [TIME_W-1:0] STEPT_MIN = TIME_W'(STEPT_MIN_MS / TICK_MS);
    localparam logic [TIME_W-1:0] STEPT_MAX = TIME_W'(STEPT_MAX_S * 1000 / TICK_MS);
    localparam logic [TIME_W-1:0] DELAY_MAX = TIME_W'(DELAY_MAX_S * 1000 / TICK_MS);
    localparam logic [TIME_W-1:0] RST_STEPT = STEPT_MIN;
    localparam logic [1:0] RST_RANGE = 2'h0;
    typedef enum logic [1:0] {
        OCTR_RNG_HIGH = 2'b00,
        OCTR_RNG_MID = 2'b01,
        OCTR_RNG_LOW = 2'b10
    } octr_range_t;
    typedef struct packed {
        logic [1:0] range;
        logic [CUR_W-1:0] start_c;
        logic [CUR_W-1:0] end_c;
        logic [CUR_W-1:0] step_c;
        logic [TIME_W-1:0] step_t;
        logic [TIME_W-1:0] delay;
        logic [VOLT_W-1:0] trig_v;
        logic [CUR_W-1:0] last_c;
    } octr_setup_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } octr_bus_t;
    typedef struct packed {
        logic [CUR_W-1:0] setpoint;
        logic [1:0] range;
        logic sink_on;
    } octr_drive_t;
endpackage
`default_nettype wire

/* test/octr_ramp_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module octr_ramp_assertions
    import octr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire octr_bus_t bus,
    input wire logic [31:0] rdata,
    input wire logic load_on,
    input wire logic mode_cc,
    input wire octr_drive_t drive
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Switch-on edge seen while in constant-current mode
    sequence s_switch_on;
        $past(load_on) && !$past(load_on, 2) && $past(mode_cc);
    endsequence
    a_rd_window: assert property (!$past(bus.rd) |-> rdata == '0)
        else $error("read data outside its cycle");
    a_unmapped_zero: assert property (bus.rd && bus.addr > REG_SETPT |=> rdata == '0)
        else $error("unmapped read not zero");
    a_setpt_read: assert property (bus.rd && bus.addr == REG_SETPT
        |=> rdata == 32'($past(drive.setpoint)))
        else $error("setpoint read differs from drive");
    a_run_read: assert property (bus.rd && bus.addr == REG_STATUS
        |=> rdata[ST_RUN_BIT] == $past(drive.sink_on))
        else $error("running bit differs from sink");
    a_switch_on: assert property ($rose(drive.sink_on) |-> s_switch_on)
        else $error("sink on without load switch-on");
    a_load_off: assert property (!load_on |=> !drive.sink_on)
        else $error("sink on with load off");
    a_cc_only: assert property (drive.sink_on |-> $past(mode_cc))
        else $error("sink on outside constant-current mode");
    a_range_hold: assert property (drive.sink_on && $past(drive.sink_on)
        |-> $stable(drive.range))
        else $error("range changed during run");
endmodule // octr_ramp_assertions
bind octr_ramp octr_ramp_assertions u_chk (.clk_sys(clk_sys), .reset(reset), .bus(bus),
    .rdata(rdata), .load_on(load_on), .mode_cc(mode_cc), .drive(drive));
`default_nettype wire

/* test/octr_psu_model.sv */
`timescale 1ns/1ns
`default_nettype none
module octr_psu_model
    import octr_pkg::*;
(
    input wire logic clk_sys,
    input wire octr_drive_t drive,
    input wire logic prot_en,
    input wire logic [CUR_W-1:0] ocp_lim,
    input wire logic [VOLT_W-1:0] v_nom,
    output logic [VOLT_W-1:0] meas_v,
    output logic [CUR_W-1:0] meas_i
);
    logic trip_q;
    // Output collapses, latched until sink off
    always_ff @(posedge clk_sys) begin
        trip_q <= drive.sink_on && (trip_q || (prot_en && drive.setpoint > ocp_lim));
    end
    assign meas_v = trip_q ? '0 : v_nom;
    assign meas_i = drive.sink_on ? drive.setpoint : '0;
endmodule // octr_psu_model
`default_nettype wire

/* test/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench
    import octr_pkg::*;
;
    logic clk_sys, reset, load_on, mode_cc, prot_en;
    octr_bus_t bus;
    logic [31:0] rdata;
    logic [VOLT_W-1:0] meas_v, v_nom;
    logic [CUR_W-1:0] meas_i;
    octr_drive_t drive;
    int fail_count, comparisons;
    always #20 clk_sys = ~clk_sys;
    octr_ramp #(.TICK_CYCLES(4)) dut (.clk_sys(clk_sys), .reset(reset), .bus(bus),
        .rdata(rdata), .load_on(load_on), .mode_cc(mode_cc), .meas_v(meas_v),
        .meas_i(meas_i), .drive(drive));
    octr_psu_model psu (.clk_sys(clk_sys), .drive(drive), .prot_en(prot_en),
        .ocp_lim(16'h17C), .v_nom(v_nom), .meas_v(meas_v), .meas_i(meas_i));
    task automatic close_out;
        if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // Bus tasks start just after an edge and release at the sampling edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus <= '0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus <= '0;
        #1 d = rdata;
    endtask
    task automatic setup(input logic [31:0] p [9]);
        for (int k = 0; k < 9; k++) wr(8'(k + 1), p[k]);
    endtask
    // Records every setpoint change; supply voltage held low for vd cycles
    task automatic ramp(input int vd, input logic [1:0] rg, input logic [CUR_W-1:0] e [5],
        input int n);
        logic [CUR_W-1:0] last;
        int t [$];
        logic [CUR_W-1:0] v [$];
        last = '0;
        v_nom <= (vd > 0) ? 16'h0 : 16'h1388;
        load_on <= 1'b1;
        for (int i = 0; i < 150; i++) begin
            @(posedge clk_sys);
            #1;
            if (i == vd) v_nom <= 16'h1388;
            if (drive.setpoint !== last) begin
                last = drive.setpoint;
                v.push_back(last);
                t.push_back(i);
            end
        end
        chk("range", 32'(rg), 32'(drive.range));
        chk("changes", 32'(n), 32'(t.size()));
        for (int k = 0; k < n; k++) chk("setpoint", 32'(e[k]), 32'(v[k]));
        chk("step_gap", 32'd20, 32'(t[2] - t[1]));
        chk("arm_wait", 32'h1, 32'(t[1] > vd));
    endtask
    task automatic t_reset;
        logic [31:0] d;
        rd(REG_STEPT, d);
        chk("step_t", 32'(RST_STEPT), d);
        rd(REG_SETPT, d);
        chk("setpoint_reg", 32'h0, d);
        rd(8'h20, d);
        chk("unmapped", 32'h0, d);
    endtask
    task automatic t_trip;
        logic [31:0] d;
        setup('{32'h3, 32'h1, 32'h64, 32'h3E8, 32'h96, 32'h5, 32'h2, 32'h3E8, 32'h28});
        wr(REG_SLOT, 32'hC);
        rd(REG_SLOT, d);
        chk("slot", 32'h3, d);
        wr(REG_RANGE, 32'h3);
        rd(REG_RANGE, d);
        chk("range_reg", 32'h1, d);
        wr(REG_CTRL, 32'h1);
        ramp(40, OCTR_RNG_MID, '{16'h64, 16'hFA, 16'h190, 16'h28, 16'h0}, 4);
        rd(REG_STATUS, d);
        chk("status", 32'h3, d);
        rd(REG_RES_I, d);
        chk("result_i", 32'h190, d);
        rd(REG_RES_V, d);
        chk("result_v", 32'h0, d);
        load_on <= 1'b0;
    endtask
    task automatic t_fail;
        logic [31:0] d;
        prot_en <= 1'b0;
        setup('{32'h5, 32'h2, 32'h64, 32'h1A4, 32'h96, 32'h5, 32'h2, 32'h3E8, 32'h28});
        ramp(0, OCTR_RNG_LOW, '{16'h64, 16'hFA, 16'h190, 16'h1A4, 16'h0}, 5);
        rd(REG_STATUS, d);
        chk("status", 32'h4, d);
        load_on <= 1'b0;
        prot_en <= 1'b1;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic try_start(input int b);
        logic [31:0] d;
        load_on <= 1'b1;
        repeat (10) @(posedge clk_sys);
        #1 chk("sink_on", 32'h0, 32'(drive.sink_on));
        rd(REG_STATUS, d);
        chk("refusal", 32'h1, 32'(d[b]));
        load_on <= 1'b0;
    endtask
    task automatic t_refuse;
        mode_cc <= 1'b0;
        try_start(ST_NOTCC_BIT);
        mode_cc <= 1'b1;
        setup('{32'h6, 32'h0, 32'h64, 32'h3E8, 32'h96, 32'h5, 32'h5, 32'h3E8, 32'h28});
        try_start(ST_BAD_BIT);
    endtask
    initial begin
        clk_sys = 1'b0;
        reset = 1'b1;
        bus = '0;
        load_on = 1'b0;
        mode_cc = 1'b1;
        prot_en = 1'b1;
        v_nom = 16'h1388;
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        #1;
        t_reset();
        t_trip();
        t_fail();
        t_refuse();
        close_out();
    end
    // Whole run needs well under 1500 cycles
    initial begin
        repeat (4000) @(posedge clk_sys);
        fail_count++;
        close_out();
    end
endmodule // testbench
`default_nettype wire
